// >>> rtl/wsrf_defs.vh
// Constants of the weigh serial report framer: offsets, fields, codes, timing.
// Assumes a 10 MHz core clock and a 32-bit APB slave port.
`ifndef WSRF_DEFS_VH
`define WSRF_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WSRF_CTRL_OFS 13'h0000
`define WSRF_WSTATE_OFS 13'h0004
`define WSRF_INTERVAL_OFS 13'h0008
`define WSRF_STATUS_OFS 13'h000C
`define WSRF_ITEM_PAGE 6'h08
`define WSRF_CTRL_RST 32'h00000000
`define WSRF_WSTATE_RST 32'h00000070
// ----------------------------------------
// Field positions
// ----------------------------------------
`define WSRF_CTRL_SEMI 0
`define WSRF_CTRL_PORT2 1
`define WSRF_CTRL_CMD 2
`define WSRF_CTRL_PRINT 3
`define WSRF_CTRL_KG 4
`define WSRF_CTRL_PIECE 5
`define WSRF_WS_STABLE 0
`define WSRF_WS_OVER 1
`define WSRF_WS_NET 2
`define WSRF_WS_NOTRANS 3
`define WSRF_WS_NOID 4
`define WSRF_WS_NOGRP 5
`define WSRF_WS_NOOP 6
// ----------------------------------------
// Element codes
// ----------------------------------------
`define WSRF_E_END 5'h00
`define WSRF_E_CRLF 5'h01
`define WSRF_E_CR 5'h02
`define WSRF_E_LF 5'h03
`define WSRF_E_SOH 5'h04
`define WSRF_E_STX 5'h05
`define WSRF_E_ETX 5'h06
`define WSRF_E_STATUS 5'h07
`define WSRF_E_NTGS 5'h08
`define WSRF_E_DATE 5'h09
`define WSRF_E_TIME 5'h0A
`define WSRF_E_NET 5'h0B
`define WSRF_E_TARE 5'h0C
`define WSRF_E_GROSS 5'h0D
`define WSRF_E_UNIT 5'h0E
`define WSRF_E_HREF 5'h0F
`define WSRF_E_LREF 5'h10
`define WSRF_E_CKRES 5'h11
`define WSRF_E_ID 5'h12
`define WSRF_E_GROUP 5'h13
`define WSRF_E_OPNUM 5'h14
`define WSRF_E_PCODE 5'h15
`define WSRF_E_CCODE 5'h16
`define WSRF_E_TRANS 5'h17
`define WSRF_E_ACC 5'h18
`define WSRF_E_AVGWT 5'h19
`define WSRF_E_COUNT 5'h1A
`define WSRF_E_TCOUNT 5'h1B
`define WSRF_E_HOLD 5'h1C
`define WSRF_E_PEAK 5'h1D
`define WSRF_E_ADRAW 5'h1E
`define WSRF_E_AVG_G 5'h1F
// ----------------------------------------
// Characters and timing
// ----------------------------------------
`define WSRF_CH_CR 8'h0D
`define WSRF_CH_LF 8'h0A
`define WSRF_CH_SP 8'h20
`define WSRF_CH_DOT 8'h2E
`define WSRF_CH_STAR 8'h2A
`define WSRF_CH_COMMA 8'h2C
`define WSRF_CH_SEMI 8'h3B
`define WSRF_VAR_LEN 5'h12
`define WSRF_CLK_NS 100
`define WSRF_TICK_NS 100000000
`endif

// >>> rtl/wsrf_framer.v
// Custom record framer and operation result command interpreter.
// Assumes byte-wide UART receive and transmit ports on core_clk, APB slave.
//
// Function
// R1 - Separator between consecutive data fields
// R2 - No separator beside control codes
// R3 - Items sent in ascending item order
// R4 - End marker emits nothing, stores record
// R5 - Output interval governs record transmission
// R6 - Port framing set outside, both ends match
// R7 - Limit fields eight characters, decimal included
// R8 - Average piece weight in grams when kg
// R9 - Piece fields meaningful only in counting
// R10 - Transaction count eight wide, blank if none
// R11 - Host frames command CR LF letter space
// R12 - Command letters decoded case sensitively
// R13 - Letters a-g and J answer results
// R14 - Letters K-V and Y answer results
// R15 - Lower n,o,p,q,y strip unit and decimal
// R16 - Letter Z returns raw converter count
// R17 - Commands only on port two command mode
// R18 - Control codes emit fixed bytes
// R19 - Status ST/US/OL, net/gross NET_GROSS_INDICATOR_FIELD
// R20 - Field widths; unset identifiers as asterisks
`timescale 1ns/10ps
`include "wsrf_defs.vh"
module wsrf_framer #(
  parameter [31:0] TICK_CYC = `WSRF_TICK_NS / `WSRF_CLK_NS
) (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_valid, // R6
  input wire [7:0] rx_data,
  output reg tx_valid,
  output reg [7:0] tx_data,
  input wire tx_ready
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_FETCH = 2'd1;
  localparam [1:0] ST_EMIT = 2'd2;
  localparam [1:0] RX_CR = 2'd0;
  localparam [1:0] RX_LF = 2'd1;
  localparam [1:0] RX_LET = 2'd2;
  localparam [1:0] RX_SP = 2'd3;
  // ----------------------------------------
  // Storage and registers
  // ----------------------------------------
  reg [7:0] chr_mem [0:1023];
  reg [4:0] item_mem [0:31];
  reg [31:0] ctrl_r;
  reg [31:0] wstate_r;
  reg [15:0] interval_r;
  reg rec_valid_r;
  reg [31:0] tick_cnt_r;
  reg [15:0] ivl_cnt_r;
  reg print_pend_r;
  reg cmd_pend_r;
  reg [1:0] rx_st_r;
  reg [7:0] letter_r;
  reg [7:0] last_cmd_r;
  reg [1:0] eng_st_r;
  reg src_cmd_r;
  reg [5:0] pos_r;
  reg [4:0] code_r;
  reg [4:0] idx_r;
  reg prev_data_r;
  reg sep_due_r;
  reg strip_r;
  reg [4:0] scr_r [0:4];
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire sel_item = (paddr[12:7] == `WSRF_ITEM_PAGE);
  wire sel_mem = paddr[12];
  wire tick = (tick_cnt_r == TICK_CYC - 32'd1);
  wire can_send = ~tx_valid | tx_ready;
  wire port_cmd = ctrl_r[`WSRF_CTRL_PORT2] & ctrl_r[`WSRF_CTRL_CMD];
  // ----------------------------------------
  // APB slave, no wait states; answers come from flops
  // ----------------------------------------
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~sel_item & ~sel_mem & (paddr > `WSRF_STATUS_OFS);
      if (apb_setup)
      begin
        if (sel_mem)
          prdata <= {24'h000000, chr_mem[paddr[11:2]]};
        else if (sel_item)
          prdata <= {27'h0000000, item_mem[paddr[6:2]]};
        else if (paddr == `WSRF_CTRL_OFS)
          prdata <= ctrl_r;
        else if (paddr == `WSRF_WSTATE_OFS)
          prdata <= wstate_r;
        else if (paddr == `WSRF_INTERVAL_OFS)
          prdata <= {16'h0000, interval_r};
        else if (paddr == `WSRF_STATUS_OFS)
          prdata <= {16'h0000, last_cmd_r, 2'b00, rx_st_r, cmd_pend_r,
                     print_pend_r, rec_valid_r, (eng_st_r != ST_IDLE)};
        else
          prdata <= 32'h00000000;
      end
    end
  end
  // Memories carry no reset; a record is never sent before its End is written
  always @(posedge core_clk)
  begin
    if (apb_wr & sel_mem)
      chr_mem[paddr[11:2]] <= pwdata[7:0];
    if (apb_wr & sel_item)
      item_mem[paddr[6:2]] <= pwdata[4:0];
  end
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `WSRF_CTRL_RST;
      wstate_r <= `WSRF_WSTATE_RST;
      interval_r <= 16'h0000;
      rec_valid_r <= 1'b0;
    end
    else
    begin
      if (apb_wr & (paddr == `WSRF_CTRL_OFS))
        ctrl_r <= {26'h0000000, pwdata[5:0]};
      else
        ctrl_r[`WSRF_CTRL_PRINT] <= 1'b0;
      if (apb_wr & (paddr == `WSRF_WSTATE_OFS))
        wstate_r <= {25'h0000000, pwdata[6:0]};
      if (apb_wr & (paddr == `WSRF_INTERVAL_OFS))
        interval_r <= pwdata[15:0]; // R5
      if (apb_wr & sel_item)
        rec_valid_r <= (pwdata[4:0] == `WSRF_E_END); // R4
    end
  end
  // ----------------------------------------
  // Output interval timer, 100 ms ticks
  // ----------------------------------------
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_r <= 32'h00000000;
      ivl_cnt_r <= 16'h0000;
    end
    else
    begin
      tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'd1;
      if (interval_r == 16'h0000)
        ivl_cnt_r <= 16'h0000;
      else if (tick)
        ivl_cnt_r <= (ivl_cnt_r >= interval_r - 16'd1) ? 16'h0000 : ivl_cnt_r + 16'd1;
    end
  end
  wire print_evt = rec_valid_r & (ctrl_r[`WSRF_CTRL_PRINT] |
    (tick & (interval_r != 16'h0000) & (ivl_cnt_r >= interval_r - 16'd1))); // R5
  // ----------------------------------------
  // Command receiver: CR, LF, letter, space
  // ----------------------------------------
  reg [4:0] c0, c1;
  reg c_ok, c_strip;
  always @*
  begin
    c0 = `WSRF_E_END;
    c1 = `WSRF_E_CRLF;
    c_ok = 1'b1;
    c_strip = 1'b0;
    case (letter_r) // R12
      8'h61: c0 = `WSRF_E_PEAK; // R13
      8'h62: c0 = `WSRF_E_PCODE;
      8'h63: c0 = `WSRF_E_TCOUNT;
      8'h64: c0 = `WSRF_E_ID;
      8'h65: c0 = `WSRF_E_GROUP;
      8'h66: c0 = `WSRF_E_OPNUM;
      8'h67: c0 = `WSRF_E_CCODE;
      8'h4A:
      begin
        c0 = `WSRF_E_STATUS;
        c1 = `WSRF_E_GROSS;
      end
      8'h4B: c0 = `WSRF_E_DATE; // R14
      8'h4C: c0 = `WSRF_E_TIME;
      8'h4D: c0 = `WSRF_E_TRANS;
      8'h4E: c0 = `WSRF_E_ACC;
      8'h4F: c0 = `WSRF_E_NET;
      8'h50: c0 = `WSRF_E_TARE;
      8'h51: c0 = `WSRF_E_GROSS;
      8'h52: c0 = `WSRF_E_HREF;
      8'h53: c0 = `WSRF_E_LREF;
      8'h54: c0 = `WSRF_E_CKRES;
      8'h55: c0 = `WSRF_E_COUNT;
      8'h56: c0 = `WSRF_E_AVGWT;
      8'h59: c0 = `WSRF_E_HOLD;
      8'h6E, 8'h6F, 8'h70, 8'h71, 8'h79: c_strip = 1'b1; // R15
      8'h5A: c0 = `WSRF_E_ADRAW; // R16
      default: c_ok = 1'b0;
    endcase
    if (c_strip)
    begin
      case (letter_r)
        8'h6E: c0 = `WSRF_E_ACC;
        8'h6F: c0 = `WSRF_E_NET;
        8'h70: c0 = `WSRF_E_TARE;
        8'h71: c0 = `WSRF_E_GROSS;
        default: c0 = `WSRF_E_HOLD;
      endcase
    end
    else if ((letter_r == 8'h4E) | (letter_r == 8'h4F) | (letter_r == 8'h50) |
             (letter_r == 8'h51) | (letter_r == 8'h59))
      c1 = `WSRF_E_UNIT;
  end
  wire cmd_done = rx_valid & (rx_st_r == RX_SP) & (rx_data == `WSRF_CH_SP) & c_ok;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_r <= RX_CR;
      letter_r <= 8'h00;
      last_cmd_r <= 8'h00;
    end
    else if (rx_valid & port_cmd) // R17
    begin
      case (rx_st_r) // R11
        RX_CR: rx_st_r <= (rx_data == `WSRF_CH_CR) ? RX_LF : RX_CR;
        RX_LF: rx_st_r <= (rx_data == `WSRF_CH_LF) ? RX_LET :
                          ((rx_data == `WSRF_CH_CR) ? RX_LF : RX_CR);
        RX_LET:
        begin
          letter_r <= rx_data;
          rx_st_r <= (rx_data == `WSRF_CH_CR) ? RX_LF : RX_SP;
        end
        RX_SP:
        begin
          rx_st_r <= (rx_data == `WSRF_CH_CR) ? RX_LF : RX_CR;
          if (cmd_done)
            last_cmd_r <= letter_r;
        end
        default: rx_st_r <= RX_CR;
      endcase
    end
  end
  // ----------------------------------------
  // Element character generation
  // ----------------------------------------
  wire kg = ctrl_r[`WSRF_CTRL_KG];
  wire [4:0] slot = ((code_r == `WSRF_E_AVGWT) & kg) ? `WSRF_E_AVG_G : code_r; // R8
  wire [7:0] raw = chr_mem[{slot, idx_r}];
  reg [7:0] ch;
  reg [4:0] len;
  always @*
  begin
    ch = raw;
    case (code_r)
      `WSRF_E_DATE: len = 5'd10; // R20
      `WSRF_E_OPNUM: len = 5'd4;
      `WSRF_E_PCODE, `WSRF_E_CCODE: len = `WSRF_VAR_LEN;
      `WSRF_E_CRLF, `WSRF_E_STATUS, `WSRF_E_NTGS, `WSRF_E_UNIT, `WSRF_E_CKRES,
      `WSRF_E_ID, `WSRF_E_GROUP: len = 5'd2;
      `WSRF_E_CR, `WSRF_E_LF, `WSRF_E_SOH, `WSRF_E_STX, `WSRF_E_ETX: len = 5'd1;
      default: len = 5'd8; // R7
    endcase
    case (code_r)
      `WSRF_E_CRLF: ch = (idx_r == 5'd0) ? `WSRF_CH_CR : `WSRF_CH_LF; // R18
      `WSRF_E_CR: ch = `WSRF_CH_CR;
      `WSRF_E_LF: ch = `WSRF_CH_LF;
      `WSRF_E_SOH: ch = 8'h01;
      `WSRF_E_STX: ch = 8'h02;
      `WSRF_E_ETX: ch = 8'h03;
      `WSRF_E_STATUS: // R19
        if (wstate_r[`WSRF_WS_OVER])
          ch = (idx_r == 5'd0) ? 8'h4F : 8'h4C;
        else if (wstate_r[`WSRF_WS_STABLE])
          ch = (idx_r == 5'd0) ? 8'h53 : 8'h54;
        else
          ch = (idx_r == 5'd0) ? 8'h55 : 8'h53;
      `WSRF_E_NTGS:
        if (wstate_r[`WSRF_WS_NET])
          ch = (idx_r == 5'd0) ? 8'h4E : 8'h54;
        else
          ch = (idx_r == 5'd0) ? 8'h47 : 8'h53;
      `WSRF_E_ID: ch = wstate_r[`WSRF_WS_NOID] ? `WSRF_CH_STAR : raw; // R20
      `WSRF_E_GROUP: ch = wstate_r[`WSRF_WS_NOGRP] ? `WSRF_CH_STAR : raw;
      `WSRF_E_OPNUM: ch = wstate_r[`WSRF_WS_NOOP] ? `WSRF_CH_STAR : raw;
      `WSRF_E_COUNT, `WSRF_E_TCOUNT:
        ch = ctrl_r[`WSRF_CTRL_PIECE] ? raw : `WSRF_CH_SP; // R9
      `WSRF_E_TRANS, `WSRF_E_ACC:
        ch = wstate_r[`WSRF_WS_NOTRANS] ? `WSRF_CH_SP : raw; // R10
      default: ch = raw;
    endcase
  end
  wire var_end = (len == `WSRF_VAR_LEN) & (raw == 8'h00);
  wire [4:0] next_code = src_cmd_r ? scr_r[pos_r[2:0]] : item_mem[pos_r[4:0]];
  wire next_data = (next_code >= `WSRF_E_STATUS);
  // Unit suffix hugs its value in command answers, as in 2.000kg
  wire unit_glued = src_cmd_r & (next_code == `WSRF_E_UNIT);
  wire list_over = src_cmd_r ? (pos_r > 6'd4) : pos_r[5];
  // ----------------------------------------
  // Sequencer; commands take priority over a due record
  // ----------------------------------------
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      eng_st_r <= ST_IDLE;
      src_cmd_r <= 1'b0;
      pos_r <= 6'd0;
      code_r <= `WSRF_E_END;
      idx_r <= 5'd0;
      prev_data_r <= 1'b0;
      sep_due_r <= 1'b0;
      strip_r <= 1'b0;
      print_pend_r <= 1'b0;
      cmd_pend_r <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      scr_r[0] <= `WSRF_E_END;
      scr_r[1] <= `WSRF_E_END;
      scr_r[2] <= `WSRF_E_END;
      scr_r[3] <= `WSRF_E_END;
      scr_r[4] <= `WSRF_E_END;
    end
    else
    begin
      if (tx_valid & tx_ready)
        tx_valid <= 1'b0;
      if (cmd_done & port_cmd & ~cmd_pend_r)
      begin
        cmd_pend_r <= 1'b1;
        scr_r[0] <= c0;
        scr_r[1] <= (letter_r == 8'h4A) ? `WSRF_E_GROSS : c1;
        scr_r[2] <= (letter_r == 8'h4A) ? `WSRF_E_TARE :
                    ((c1 == `WSRF_E_UNIT) ? `WSRF_E_CRLF : `WSRF_E_END);
        scr_r[3] <= (letter_r == 8'h4A) ? `WSRF_E_CRLF : `WSRF_E_END;
        scr_r[4] <= `WSRF_E_END;
        strip_r <= c_strip;
      end
      if (print_evt)
        print_pend_r <= 1'b1;
      case (eng_st_r)
        ST_IDLE:
        begin
          pos_r <= 6'd0;
          prev_data_r <= 1'b0;
          if (cmd_pend_r)
          begin
            src_cmd_r <= 1'b1;
            eng_st_r <= ST_FETCH;
          end
          else if (print_pend_r & ~print_evt)
          begin
            print_pend_r <= 1'b0;
            src_cmd_r <= 1'b0;
            eng_st_r <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (list_over | (next_code == `WSRF_E_END)) // R4
          begin
            eng_st_r <= ST_IDLE;
            if (src_cmd_r)
              cmd_pend_r <= 1'b0;
          end
          else if (~(strip_r & src_cmd_r & (next_code == `WSRF_E_UNIT)))
          begin
            code_r <= next_code;
            idx_r <= 5'd0;
            sep_due_r <= next_data & prev_data_r & ~unit_glued; // R1 R2
            prev_data_r <= next_data; // R2
            eng_st_r <= ST_EMIT;
          end
          pos_r <= pos_r + 6'd1; // R3
        end
        ST_EMIT:
        begin
          if (can_send)
          begin
            if (sep_due_r)
            begin
              tx_valid <= 1'b1;
              tx_data <= ctrl_r[`WSRF_CTRL_SEMI] ? `WSRF_CH_SEMI : `WSRF_CH_COMMA; // R1
              sep_due_r <= 1'b0;
            end
            else if ((idx_r == len) | var_end)
              eng_st_r <= ST_FETCH;
            else if (strip_r & src_cmd_r & (ch == `WSRF_CH_DOT))
              idx_r <= idx_r + 5'd1; // R15
            else
            begin
              tx_valid <= 1'b1;
              tx_data <= ch;
              idx_r <= idx_r + 5'd1;
            end
          end
        end
        default: eng_st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> verif/wsrf_framer_properties.sv
// Checks on the framer's APB and byte stream ports.
// Assumes a bind into wsrf_framer.
`timescale 1ns/10ps
module wsrf_framer_properties (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_ready
);
  // Last accepted byte; control bytes may never touch a separator
  reg [7:0] last_r;
  wire hs = tx_valid && tx_ready;
  wire sep = tx_data == 8'h2C || tx_data == 8'h3B;
  wire ctl_now = tx_data < 8'h04 || tx_data == 8'h0D || tx_data == 8'h0A;
  wire ctl_last = last_r < 8'h04 || last_r == 8'h0D || last_r == 8'h0A;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      last_r <= 8'h00;
    else if (hs)
      last_r <= tx_data;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  answer_next_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (psel && !penable && paddr >= 13'h0010 &&
    paddr < 13'h0400 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  mapped_ok_a: assert property (psel && !penable && paddr < 13'h0010 |=> !pslverr)
    else $error("mapped access refused");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped before acceptance");
  sep_after_ctl_a: assert property (hs && sep |-> !ctl_last)
    else $error("separator after control code");
  ctl_after_sep_a: assert property (hs && ctl_now && last_r != 8'h00 |->
    !(last_r == 8'h2C || last_r == 8'h3B))
    else $error("separator before control code");
endmodule
bind wsrf_framer wsrf_framer_properties chk (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

// >>> verif/wsrf_host_model.sv
// Host on the framer's byte ports: sends commands, collects replies.
// Assumes command() is called right after a rising clock edge.
`timescale 1ns/10ps
module wsrf_host_model (
  input wire core_clk,
  output reg rx_valid,
  output reg [7:0] rx_data,
  input wire tx_valid,
  input wire [7:0] tx_data,
  output reg tx_ready
);
  reg [7:0] got[$];
  reg slow;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    slow = 1'b0;
  end
  // Slow mode stalls at random so the framer must hold each byte
  always @(posedge core_clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  end
  // Idle line shows the inverse of the last byte, never a stale copy
  task send(input [7:0] b);
    begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_data <= ~b;
    end
  endtask
  // Byte framing is settled outside; bytes arrive already matched
  task command(input [7:0] ltr);
    begin
      send(8'h0D);
      send(8'h0A);
      send(ltr);
      send(8'h20);
    end
  endtask
endmodule

// >>> verif/wsrf_framer_tb_top.sv
// Self-checking bench of the weigh serial report framer.
// Assumes the host model on the byte side and the checker bound in.
`timescale 1ns/10ps
`define CHK(n, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("BAD %s exp %h got %h", n, e, g); \
    end \
  end
module wsrf_framer_tb_top;
  reg core_clk;
  reg rst;
  reg psel;
  reg penable;
  reg pwrite;
  reg [12:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire rx_valid;
  wire [7:0] rx_data;
  wire tx_valid;
  wire [7:0] tx_data;
  wire tx_ready;
  integer mismatches;
  integer n_checks;
  integer i;
  integer s;
  integer c;
  reg [31:0] rdat;
  reg rerr;
  reg [7:0] fld [0:31][0:7];
  reg [7:0] exp_q[$];
  string lt;
  wsrf_framer #(.TICK_CYC(32'd10)) uut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  wsrf_host_model host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  always #50 core_clk = ~core_clk;
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // APB master and expectation helpers
  // ----------------------------------------
  // Request stands until pready is seen high at a rising edge; answer taken there
  task apb(input [12:0] a, input w, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && k < 20)
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      if (pready !== 1'b1)
      begin
        mismatches++;
        complete_run;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task wr(input [12:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input [12:0] a, input [31:0] e, input ee);
    begin
      apb(a, 1'b0, 32'h0);
      `CHK("rdata", e, rdat)
      `CHK("pslverr", ee, rerr)
    end
  endtask
  task items(input [47:0] codes);
    integer k;
    for (k = 0; k < 6; k = k + 1)
      wr(13'(13'h0400 + 4 * k), {27'h0, codes[44 - 8 * k -: 5]});
  endtask
  function void add_f(input integer sl, input bit nodot);
    integer k;
    for (k = 0; k < 8; k = k + 1)
      if (!(nodot && fld[sl][k] == 8'h2E))
        exp_q.push_back(fld[sl][k]);
  endfunction
  function void push_s(input string t);
    integer k;
    for (k = 0; k < t.len(); k = k + 1)
      exp_q.push_back(t[k]);
  endfunction
  // Waits for the expected count, then lingers to catch extra bytes
  task check_out(input string nm);
    integer k;
    begin
      k = 0;
      while (host.got.size() < exp_q.size() && k < 3000)
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      repeat (80) @(posedge core_clk);
      `CHK({nm, " count"}, exp_q.size(), host.got.size())
      for (k = 0; k < exp_q.size() && k < host.got.size(); k = k + 1)
        `CHK(nm, exp_q[k], host.got[k])
      exp_q.delete();
      host.got.delete();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 13'h0000;
    pwdata = 32'h0;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(9204));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(13'h0000, 32'h00000000, 1'b0);
    rd(13'h0004, 32'h00000070, 1'b0);
    rd(13'h0008, 32'h00000000, 1'b0);
    rd(13'h0010, 32'h00000000, 1'b1);
    for (s = 11; s < 32; s = s + 1)
      for (c = 0; c < 8 && (s < 15 || s == 31); c = c + 1)
      begin
        fld[s][c] = (c == 4) ? 8'h2E : 8'h30 + 8'($urandom_range(9));
        wr(13'(13'h1000 + 128 * s + 4 * c), {24'h0, fld[s][c]});
      end
    wr(13'h0004, 32'h00000001);
    items(48'h0B0C05070100);
    wr(13'h0000, 32'h00000008);
    add_f(11, 0);
    push_s(",");
    add_f(12, 0);
    push_s("\002ST\015\012");
    check_out("record comma");
    host.slow = 1'b1;
    wr(13'h0004, 32'h0000001E);
    items(48'h07081A171200);
    wr(13'h0000, 32'h00000009);
    push_s("OL;NT;        ;        ;**");
    check_out("record semicolon");
    wr(13'h0008, 32'h00000001);
    repeat (300) @(posedge core_clk);
    wr(13'h0008, 32'h00000000);
    repeat (400) @(posedge core_clk);
    `CHK("interval", 1'b1, host.got.size() >= 52 && host.got.size() % 26 == 0)
    host.got.delete();
    wr(13'h0414, 32'h0000000B);
    apb(13'h000C, 1'b0, 32'h0);
    `CHK("record valid", 1'b0, rdat[1])
    wr(13'h0000, 32'h00000008);
    check_out("no record");
    host.slow = 1'b0;
    wr(13'h0004, 32'h00000011);
    wr(13'h0000, 32'h00000006);
    lt = "opq";
    for (i = 0; i < 3; i = i + 1)
    begin
      host.command(lt[i]);
      add_f(11 + i, 1);
      push_s("\015\012");
      check_out("plain value");
    end
    host.command("d");
    push_s("**\015\012");
    check_out("machine id");
    host.command("J");
    push_s("ST,");
    add_f(13, 0);
    push_s(",");
    add_f(12, 0);
    push_s("\015\012");
    check_out("status weight tare");
    host.command("X");
    check_out("unknown letter");
    host.command("O");
    add_f(11, 0);
    for (i = 0; i < 3000 && host.got.size() < 12; i = i + 1)
      @(posedge core_clk);
    repeat (80) @(posedge core_clk);
    for (i = 0; i < 8; i = i + 1)
      `CHK("upper net", exp_q[i], host.got[i])
    `CHK("upper unit", {fld[14][0], fld[14][1]}, {host.got[8], host.got[9]})
    `CHK("upper end", 8'h0A, host.got[host.got.size() - 1])
    exp_q.delete();
    host.got.delete();
    wr(13'h0000, 32'h00000016);
    host.command("V");
    add_f(31, 0);
    push_s("\015\012");
    check_out("grams");
    wr(13'h0000, 32'h00000004);
    host.command("o");
    check_out("port one");
    complete_run;
  end
endmodule
